// >>> tbrd_baseline.sv
// Baseline tracking, detect integrator and recalibration control
`timescale 1ns/1ps
module tbrd_baseline #(
  parameter int SIG_W = tbrd_pkg::SIG_W,
  parameter int LONG_DET_BURSTS = tbrd_pkg::LONG_DET_BURSTS,
  parameter int STEP_UP_BURSTS = tbrd_pkg::STEP_UP_BURSTS,
  parameter int STEP_DN_BURSTS = tbrd_pkg::STEP_DN_BURSTS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic burst_active,
  input wire logic burst_done,
  input wire logic [SIG_W-1:0] burst_signal,
  input wire logic multiplier_select_level,
  output logic detect_ff,
  output logic recal_ff,
  output logic override_ff,
  output logic [SIG_W-1:0] reference_ff,
  output logic [4:0] osc_trim_ff
);
  localparam int CW = 24;
  tbrd_pkg::tbrd_state_type state_ff, nxt_state;
  logic [2:0] consecutive_detect_counter_ff, nxt_cdc;
  logic [CW-1:0] long_cnt_ff, nxt_long_cnt;
  logic [CW-1:0] up_cnt_ff, nxt_up_cnt;
  logic [CW-1:0] dn_cnt_ff, nxt_dn_cnt;
  logic [2:0] cal_cnt_ff, nxt_cal_cnt;
  logic [SIG_W-1:0] nxt_reference;
  logic nxt_detect, nxt_recal, nxt_override;
  logic [4:0] trim_w;

  // Terminal-count test shared by every burst counter; a limit of N bursts ends on
  // count N-1, so the counter never needs a wider compare than its own width
  function automatic logic at_limit(input logic [CW-1:0] cnt, input int limit);
    at_limit = (cnt == CW'(limit - 1));
  endfunction

  // Threshold and hysteresis ride on the reference. A reference within ten counts of
  // full scale wraps the threshold, so the raw count is assumed to stay well below it
  wire [SIG_W-1:0] thresh_lvl = reference_ff + SIG_W'(tbrd_pkg::THRESH_COUNTS);
  wire [SIG_W-1:0] release_lvl = thresh_lvl - SIG_W'(tbrd_pkg::HYST_COUNTS);
  wire over_thresh = burst_signal >= thresh_lvl;
  wire above_release = burst_signal >= release_lvl;

  // Direction of the raw signal against the reference
  wire below_ref = burst_signal < reference_ff;
  wire above_ref = burst_signal > reference_ff;

  // State decodes
  wire in_cal = state_ff == tbrd_pkg::TBRD_CAL;
  wire in_track = state_ff == tbrd_pkg::TBRD_TRACK;
  wire in_det = state_ff == tbrd_pkg::TBRD_DETECT;
  wire cal_last = at_limit(CW'(cal_cnt_ff), tbrd_pkg::CAL_BURSTS);

  // The fourth over-threshold burst in a row confirms a touch
  wire confirm = in_track && over_thresh &&
                 (consecutive_detect_counter_ff == tbrd_pkg::DETECT_CONFIRM - 3'h1);

  // Recal sources; the override release only acts at the next burst end, which keeps
  // every state change on the acquisition cadence
  wire long_expire = in_det && at_limit(long_cnt_ff, LONG_DET_BURSTS);
  wire override_release = override_ff && !multiplier_select_level;
  wire recal_req = long_expire || override_release;

  // Step intervals are due on the last burst of each interval
  wire up_due = at_limit(up_cnt_ff, STEP_UP_BURSTS);
  wire dn_due = at_limit(dn_cnt_ff, STEP_DN_BURSTS);

  // Tracking steps only while idle and clear of the threshold; a possible touch that
  // has not yet confirmed must not pull the reference up toward it
  wire track_ok = in_track && burst_done && !over_thresh;
  wire step_up = track_ok && above_ref && up_due;
  wire step_dn = track_ok && below_ref && dn_due;

  // State sequencing; a recal request overrides any other move on the same burst
  always_comb begin
    nxt_state = state_ff;
    if (burst_done) begin
      case (state_ff)
        tbrd_pkg::TBRD_CAL: begin
          if (cal_last) begin
            nxt_state = tbrd_pkg::TBRD_TRACK;
          end
        end
        tbrd_pkg::TBRD_TRACK: begin
          if (confirm) begin
            nxt_state = tbrd_pkg::TBRD_DETECT;
          end
        end
        tbrd_pkg::TBRD_DETECT: begin
          if (!above_release) begin
            nxt_state = tbrd_pkg::TBRD_TRACK;
          end
        end
        default: begin
          nxt_state = tbrd_pkg::TBRD_CAL;
        end
      endcase
      if (recal_req) begin
        nxt_state = tbrd_pkg::TBRD_CAL;
      end
    end
  end

  // Detect integrator: grows on each over-threshold burst in tracking before the confirming one, clears on any miss and on confirm
  wire run_grows = in_track && over_thresh && !confirm;
  assign nxt_cdc = !burst_done ? consecutive_detect_counter_ff :
                   run_grows ? consecutive_detect_counter_ff + 3'h1 : 3'h0;

  // Long-detection timer counts bursts spent in detection and restarts on leaving it;
  // the default limit assumes the fast burst cadence held while a touch stands
  wire long_grows = in_det && !long_expire;
  assign nxt_long_cnt = !burst_done ? long_cnt_ff :
                        long_grows ? long_cnt_ff + CW'(1) : CW'(0);

  // Step interval counters; a burst on the other side of the reference restarts the
  // interval, so noise around the reference never adds up to a step
  assign nxt_up_cnt = !track_ok ? up_cnt_ff :
                      (!above_ref || up_due) ? CW'(0) : up_cnt_ff + CW'(1);
  assign nxt_dn_cnt = !track_ok ? dn_cnt_ff :
                      (!below_ref || dn_due) ? CW'(0) : dn_cnt_ff + CW'(1);

  // Calibration burst counter, held at zero outside calibration
  assign nxt_cal_cnt = (!in_cal || recal_req) ? 3'h0 :
                       burst_done ? cal_cnt_ff + 3'h1 : cal_cnt_ff;

  // Calibration loads the raw signal; tracking moves one count at a time.
  // The load takes priority, though a step can only arise in tracking anyway
  assign nxt_reference = (burst_done && in_cal) ? burst_signal :
                         step_up ? reference_ff + SIG_W'(1) :
                         step_dn ? reference_ff - SIG_W'(1) :
                         reference_ff;

  // Detect output follows the integrator; a recal request, from long detection or from
  // the override release, drops detection
  assign nxt_detect = !burst_done ? detect_ff :
                      recal_req ? 1'b0 :
                      confirm ? 1'b1 :
                      (in_det && !above_release) ? 1'b0 : detect_ff;

  // Recal stays high from the triggering burst until the last calibration burst, so a
  // host watching it sees the whole window in which touches are not reported
  assign nxt_recal = burst_done ? (recal_req || (in_cal && !cal_last)) : recal_ff;

  // Override level is taken once per acquisition cycle, at the burst end
  assign nxt_override = burst_done ? multiplier_select_level : override_ff;

  // Spread-spectrum sweep lives in its own module so its trim width stays local
  tbrd_spread #(
    .STEPS(tbrd_pkg::SPREAD_STEPS)
  ) u_spread (
    .clk(clk),
    .rst_b(rst_b),
    .burst_active(burst_active),
    .trim_code_ff(trim_w)
  );

  // Sequencer state and detect integrator; reset doubles as the supply-cycle forced recal
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= tbrd_pkg::TBRD_CAL;
      consecutive_detect_counter_ff <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      consecutive_detect_counter_ff <= nxt_cdc;
    end
  end

  // Burst interval counters
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      long_cnt_ff <= '0;
      up_cnt_ff <= '0;
      dn_cnt_ff <= '0;
      cal_cnt_ff <= 3'h0;
    end else begin
      long_cnt_ff <= nxt_long_cnt;
      up_cnt_ff <= nxt_up_cnt;
      dn_cnt_ff <= nxt_dn_cnt;
      cal_cnt_ff <= nxt_cal_cnt;
    end
  end

  // Reference level; zero out of reset until the first calibration burst loads it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reference_ff <= '0;
    end else begin
      reference_ff <= nxt_reference;
    end
  end

  // Status outputs; recal reads high out of reset since calibration starts at once
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      detect_ff <= 1'b0;
      recal_ff <= 1'b1;
      override_ff <= 1'b0;
    end else begin
      detect_ff <= nxt_detect;
      recal_ff <= nxt_recal;
      override_ff <= nxt_override;
    end
  end

  // Trim is registered once more so every top-level output leaves a flip-flop
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_trim_ff <= 5'h00;
    end else begin
      osc_trim_ff <= trim_w;
    end
  end
endmodule

// >>> tbrd_pkg.sv
// Shared constants for the touch baseline drift and recalibration block
package tbrd_pkg;
  localparam int SIG_W = 16;
  localparam logic [15:0] THRESH_COUNTS = 16'h000a;
  localparam logic [15:0] HYST_COUNTS = 16'h0002;
  localparam logic [2:0] DETECT_CONFIRM = 3'h4;
  localparam int LONG_DET_S = 30;
  localparam int FAST_BURST_US = 2600;
  localparam int LONG_DET_BURSTS = (LONG_DET_S * 1000000) / FAST_BURST_US;
  localparam int STEP_UP_BURSTS = 64;
  localparam int STEP_DN_BURSTS = 4;
  localparam int CAL_BURSTS = 4;
  localparam int SPREAD_PERMIL = 75;
  localparam int SPREAD_STEPS = 16;
  localparam logic [15:0] ZERO16 = 16'h0000;
  typedef enum logic [1:0] {
    TBRD_CAL,
    TBRD_TRACK,
    TBRD_DETECT
  } tbrd_state_type;
endpackage

// >>> tbrd_spread.sv
// Triangle sweep of the oscillator trim code during a measurement burst
`timescale 1ns/1ps
module tbrd_spread #(
  parameter int STEPS = tbrd_pkg::SPREAD_STEPS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic burst_active,
  output logic [4:0] trim_code_ff
);
  logic up_ff;
  logic [4:0] nxt_trim;
  logic nxt_up;
  wire at_top = (trim_code_ff == 5'(STEPS - 1));
  wire at_bot = (trim_code_ff == 5'h00);
  // Sweep only within bursts; idle code is mid-range so idle frequency is nominal
  assign nxt_up = at_top ? 1'b0 : (at_bot ? 1'b1 : up_ff);
  assign nxt_trim = !burst_active ? 5'(STEPS / 2) :
                    (nxt_up ? trim_code_ff + 5'h01 : trim_code_ff - 5'h01);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trim_code_ff <= 5'h00;
      up_ff <= 1'b1;
    end else begin
      trim_code_ff <= nxt_trim;
      up_ff <= burst_active ? nxt_up : 1'b1;
    end
  end
endmodule

// >>> tbrd_electrode.sv
// Behavioural sense electrode making bursts and raw counts
`timescale 1ns/1ps
module tbrd_electrode (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [15:0] level,
  output logic burst_active,
  output logic burst_done,
  output logic [15:0] burst_signal
);
  logic [2:0] cnt_ff;
  // Count is only valid with the done pulse, so it churns otherwise
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {cnt_ff, burst_active, burst_done, burst_signal} <= '0;
    end else begin
      burst_done <= 1'b0;
      burst_signal <= ~burst_signal;
      if (start) begin
        burst_active <= 1'b1;
        cnt_ff <= 3'h3;
      end else if (burst_active) begin
        cnt_ff <= cnt_ff - 3'h1;
        burst_active <= cnt_ff != 3'h0;
        burst_done <= cnt_ff == 3'h0;
        if (cnt_ff == 3'h0) burst_signal <= level;
      end
    end
  end
endmodule

// >>> tbrd_chk_assertions.sv
// Port checker for the baseline block
`timescale 1ns/1ps
module tbrd_chk #(
  parameter int LONG_DET_BURSTS = 20
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic burst_active,
  input wire logic burst_done,
  input wire logic [15:0] burst_signal,
  input wire logic multiplier_select_level,
  input wire logic detect_ff,
  input wire logic recal_ff,
  input wire logic override_ff,
  input wire logic [15:0] reference_ff,
  input wire logic [4:0] osc_trim_ff
);
  logic [2:0] over_ff;
  logic [15:0] det_ff;
  wire logic hit = burst_signal >= reference_ff + 16'h000a && !recal_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Over-threshold run and bursts spent in detection
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      over_ff <= 3'h0;
      det_ff <= 16'h0000;
    end else if (burst_done) begin
      over_ff <= hit ? over_ff + {2'b00, over_ff != 3'h7} : 3'h0;
      det_ff <= detect_ff ? det_ff + 16'h0001 : 16'h0000;
    end
  end
  AST_CONFIRM: assert property ($rose(detect_ff) |-> over_ff == 3'h4)
    else $error("detect rose without four hits");
  AST_FREEZE: assert property (detect_ff |=> $stable(reference_ff) || recal_ff)
    else $error("reference moved in detect");
  AST_SLEW: assert property (!recal_ff && !$past(recal_ff) |->
    reference_ff - $past(reference_ff) inside {16'h0000, 16'h0001, 16'hffff})
    else $error("reference step above one");
  AST_QUIET: assert property (!burst_done |=> $stable(reference_ff) && $stable(detect_ff))
    else $error("change without burst");
  AST_OVR: assert property (burst_done |=> override_ff == $past(multiplier_select_level))
    else $error("override not sampled");
  AST_RELEASE: assert property (burst_done && override_ff && !multiplier_select_level |=> recal_ff)
    else $error("release without recal");
  AST_SWEEP: assert property (burst_active [*2] |=> osc_trim_ff != $past(osc_trim_ff))
    else $error("trim idle in burst");
  AST_LONG: assert property (int'(det_ff) <= LONG_DET_BURSTS)
    else $error("detect outlived timeout");
endmodule

// >>> tb_touch_baseline_recal_drift.sv
// Testbench for the baseline block
`timescale 1ns/1ps
module tb_touch_baseline_recal_drift;
  localparam logic [15:0] B = 16'h03e8;
  logic clk = 0, rst_b = 0, start = 0, msl = 0, chk = 0;
  logic [15:0] level = 16'h0000, sig, ref_v;
  logic act, done, det, rec, ovr;
  logic [4:0] trim;
  logic [34:0] notes[$];
  int bad_count = 0, num_checks = 0;
  integer seed = 32'h3987_3175;
  tbrd_electrode pad_u (.clk(clk), .rst_b(rst_b), .start(start), .level(level),
    .burst_active(act), .burst_done(done), .burst_signal(sig));
  tbrd_baseline #(.LONG_DET_BURSTS(20), .STEP_UP_BURSTS(8), .STEP_DN_BURSTS(2)) dut_u (
    .clk(clk), .rst_b(rst_b), .burst_active(act), .burst_done(done), .burst_signal(sig),
    .multiplier_select_level(msl), .detect_ff(det), .recal_ff(rec), .override_ff(ovr),
    .reference_ff(ref_v), .osc_trim_ff(trim));
  initial forever #12.5 clk = ~clk;
  task close_out;
    if (notes.size() != 0) begin
      $display("ERROR pending_notes exp %0d seen %0d", 0, notes.size());
      bad_count++;
    end
    if (bad_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // One burst; the note is kept only when c is set
  task burst(input logic [15:0] lv, input logic c, input logic [34:0] e);
    int i;
    level = lv;
    chk = c;
    start = 1;
    if (c) notes.push_back(e);
    @(posedge clk);
    #2 start = 0;
    for (i = 0; i < 20 && done !== 1'b1; i++) @(posedge clk) #2;
    if (i == 20) begin
      bad_count++;
      close_out;
    end
    @(posedge clk) #2;
  endtask
  function logic [15:0] touch;
    touch = B + 16'h000c + 16'($random(seed) & 32'h0000_0007);
  endfunction
  task cmp(input logic [34:0] e);
    num_checks++;
    if ({det, rec, ovr} !== e[34:32] || (ref_v >= e[31:16] && ref_v <= e[15:0]) !== 1'b1) begin
      $display("ERROR state exp %h seen %h", e, {det, rec, ovr, ref_v});
      bad_count++;
    end
  endtask
  task cmp_trim(input logic [4:0] e);
    num_checks++;
    if (trim !== e) begin
      $display("ERROR osc_trim exp %h seen %h", e, trim);
      bad_count++;
    end
  endtask
  // Result is settled just after the edge taking the pulse
  always @(posedge clk) if (done && chk) #1 cmp(notes.pop_front());
  initial begin
    repeat (10) @(posedge clk);
    #2 rst_b = 1;
    repeat (3) burst(B, 0, 0);
    burst(B, 1, {3'b000, B, B});
    repeat (3) burst(touch(), 0, 0);
    burst(B + 16'h0009, 1, {3'b000, B, B + 16'h0001});
    repeat (3) burst(touch(), 0, 0);
    burst(touch(), 1, {3'b100, B, B + 16'h0001});
    burst(B + 16'h0009, 1, {3'b100, B, B});
    burst(B, 1, {3'b000, B, B});
    repeat (25) burst(touch(), 0, 0);
    burst(touch(), 1, {3'b010, B, B + 16'h0013});
    repeat (4) burst(B, 0, 0);
    burst(B, 1, {3'b000, B, B});
    repeat (7) burst(B - 16'h0032, 0, 0);
    burst(B - 16'h0032, 1, {3'b000, B - 16'h0004, B - 16'h0003});
    repeat (7) burst(B, 0, 0);
    burst(B, 1, {3'b000, B - 16'h0004, B - 16'h0002});
    msl = 1;
    burst(B, 1, {3'b001, B - 16'h0004, B - 16'h0002});
    msl = 0;
    burst(B, 1, {3'b010, B - 16'h0004, B});
    @(posedge clk) #2;
    cmp_trim(5'(tbrd_pkg::SPREAD_STEPS / 2));
    close_out;
  end
  // Fixed-size figures travel to the checker unchanged
endmodule
bind tbrd_baseline tbrd_chk #(.LONG_DET_BURSTS(LONG_DET_BURSTS)) chk_u (.clk(clk),
  .rst_b(rst_b), .burst_active(burst_active), .burst_done(burst_done),
  .burst_signal(burst_signal), .multiplier_select_level(multiplier_select_level),
  .detect_ff(detect_ff), .recal_ff(recal_ff), .override_ff(override_ff),
  .reference_ff(reference_ff), .osc_trim_ff(osc_trim_ff));
